/* core/drive_ctl.sv */
// power state machine with command, status, error and target speed words
`timescale 1ns/100ps
`default_nettype none
module drive_ctl (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        reg_wr,
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    input  wire logic [31:0] error_newest,
    input  wire logic        fault_in,
    input  wire logic        fault_clearable,
    input  wire logic        fault_react_done,
    input  wire logic        init_done,
    input  wire logic        bus_sync,
    input  wire logic        setup_ok,
    input  wire logic        index_seen,
    input  wire logic        goal_reached_flag,
    input  wire logic        warn_in,
    input  wire logic [7:0]  op_mode,
    input  wire logic [1:0]  mode_status_bits,
    input  wire logic [15:0] speed_min,
    output logic      [15:0] last_error_code,
    output logic      [15:0] command_word,
    output logic      [15:0] state_word,
    output logic      [15:0] speed_demand,
    output logic      [3:0]  mode_specific_bits,
    output logic             halt_active,
    output logic             power_applied_flag,
    output logic             run_enable_out
);
    // reset release through two flops
    logic rst_meta, rst_sync_n;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // pin inputs through two flops each; the first stage feeds only the second
    localparam int npin = 9;
    wire  [npin-1:0] pin_raw = {fault_in, fault_clearable, fault_react_done, init_done,
                                bus_sync, setup_ok, index_seen, goal_reached_flag, warn_in};
    logic [npin-1:0] pin_meta, pin_s;
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_meta <= '0;
            pin_s    <= '0;
        end else if (clk_en) begin
            pin_meta <= pin_raw;
            pin_s    <= pin_meta;
        end
    end
    wire fault_s     = pin_s[8];
    wire clearable_s = pin_s[7];
    wire react_done  = pin_s[6];
    wire init_s      = pin_s[5];
    wire sync_s      = pin_s[4];
    wire setup_s     = pin_s[3];
    wire index_s     = pin_s[2];
    wire goal_s      = pin_s[1];
    wire warn_s      = pin_s[0];

    // register writes; read-only words ignore writes
    logic [15:0] command_word_reg, target_speed_reg;
    wire wr_cmd = reg_wr && (reg_addr == drive_ctl_pkg::command_word_off);
    wire wr_spd = reg_wr && (reg_addr == drive_ctl_pkg::target_speed_off);
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            command_word_reg <= drive_ctl_pkg::command_word_rst;
            target_speed_reg <= drive_ctl_pkg::target_speed_rst;
        end else if (clk_en) begin
            if (wr_cmd) begin
                command_word_reg <= reg_wdata;
            end
            if (wr_spd) begin
                target_speed_reg <= reg_wdata;
            end
        end
    end

    // error code mirrors the low half of the newest history entry
    logic [15:0] last_error_reg;
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            last_error_reg <= drive_ctl_pkg::last_error_rst;
        end else if (clk_en) begin
            last_error_reg <= error_newest[15:0];
        end
    end

    // command decode
    wire switch_on_bit   = command_word_reg[drive_ctl_pkg::cw_switch_on];
    wire energize_bit    = command_word_reg[drive_ctl_pkg::cw_energize];
    wire fast_halt_n     = command_word_reg[drive_ctl_pkg::cw_fast_halt];
    wire run_enable_bit  = command_word_reg[drive_ctl_pkg::cw_run_enable];
    wire clear_fault_bit = command_word_reg[drive_ctl_pkg::cw_clear_fault];
    wire halt_bit        = command_word_reg[drive_ctl_pkg::cw_halt];
    // clear is an edge so a held bit cannot loop fault -> inhibited -> fault
    logic clear_prev_reg;
    wire  clear_rise = clear_fault_bit && !clear_prev_reg;

    // power state machine
    drive_ctl_pkg::power_state_t state_reg, state_next;
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            drive_ctl_pkg::st_not_ready: begin
                if (init_s) state_next = drive_ctl_pkg::st_inhibited;
            end
            drive_ctl_pkg::st_inhibited: begin
                if (energize_bit && fast_halt_n && !switch_on_bit)
                    state_next = drive_ctl_pkg::st_ready;
            end
            drive_ctl_pkg::st_ready: begin
                if (!energize_bit || !fast_halt_n) state_next = drive_ctl_pkg::st_inhibited;
                else if (switch_on_bit) state_next = drive_ctl_pkg::st_switched;
            end
            drive_ctl_pkg::st_switched: begin
                if (!energize_bit || !fast_halt_n) state_next = drive_ctl_pkg::st_inhibited;
                else if (!switch_on_bit) state_next = drive_ctl_pkg::st_ready;
                else if (run_enable_bit) state_next = drive_ctl_pkg::st_running;
            end
            drive_ctl_pkg::st_running: begin
                if (!energize_bit) state_next = drive_ctl_pkg::st_inhibited;
                else if (!fast_halt_n) state_next = drive_ctl_pkg::st_fast_halt;
                else if (!switch_on_bit) state_next = drive_ctl_pkg::st_ready;
                else if (!run_enable_bit) state_next = drive_ctl_pkg::st_switched;
            end
            drive_ctl_pkg::st_fast_halt: begin
                // leaves only when power is dropped or a new fault arrives; stop ramp is outside this block
                if (!energize_bit) state_next = drive_ctl_pkg::st_inhibited;
            end
            drive_ctl_pkg::st_fault_react: begin
                if (react_done) state_next = drive_ctl_pkg::st_fault;
            end
            drive_ctl_pkg::st_fault: begin
                if (clear_rise && clearable_s && !fault_s)
                    state_next = drive_ctl_pkg::st_inhibited;
            end
        endcase
        // a new fault overrides any non-fault state
        if (fault_s && state_reg != drive_ctl_pkg::st_fault
                    && state_reg != drive_ctl_pkg::st_fault_react)
            state_next = drive_ctl_pkg::st_fault_react;
    end
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_reg      <= drive_ctl_pkg::st_not_ready;
            clear_prev_reg <= 1'b0;
        end else if (clk_en) begin
            state_reg      <= state_next;
            clear_prev_reg <= clear_fault_bit;
        end
    end

    // halt honoured only in the listed modes
    wire halt_mode = (op_mode == drive_ctl_pkg::mode_profile_pos)
                  || (op_mode == drive_ctl_pkg::mode_velocity)
                  || (op_mode == drive_ctl_pkg::mode_profile_vel)
                  || (op_mode == drive_ctl_pkg::mode_profile_trq)
                  || (op_mode == drive_ctl_pkg::mode_interp_pos);
    wire halt_next = halt_bit && halt_mode;

    // speed clamp against the configured minimum
    wire signed [15:0] tgt = target_speed_reg;
    wire signed [15:0] vmin = speed_min;
    wire below_min = tgt < vmin;
    wire [15:0] speed_next = below_min ? speed_min : target_speed_reg;

    // status pattern per state
    logic [6:0] state_bits;
    always_comb begin
        state_bits = 7'h00;
        unique case (state_reg)
            drive_ctl_pkg::st_not_ready:   state_bits = 7'b0000000;
            drive_ctl_pkg::st_inhibited:   state_bits = 7'b1000000;
            drive_ctl_pkg::st_ready:       state_bits = 7'b0110001;
            drive_ctl_pkg::st_switched:    state_bits = 7'b0110011;
            drive_ctl_pkg::st_running:     state_bits = 7'b0110111;
            drive_ctl_pkg::st_fast_halt:   state_bits = 7'b0000111;
            drive_ctl_pkg::st_fault_react: state_bits = 7'b0001111;
            drive_ctl_pkg::st_fault:       state_bits = 7'b0001000;
        endcase
    end
    logic [15:0] status_next;
    always_comb begin
        status_next = 16'h0000;
        status_next[6:0] = state_bits;
        status_next[drive_ctl_pkg::sw_warn]    = warn_s;
        status_next[drive_ctl_pkg::sw_sync]    = sync_s;
        status_next[drive_ctl_pkg::sw_host]    = 1'b1;
        status_next[drive_ctl_pkg::sw_goal]    = goal_s;
        status_next[drive_ctl_pkg::sw_limit]   = below_min;
        status_next[13:12]                     = mode_status_bits;
        status_next[drive_ctl_pkg::sw_loop_ok] = setup_s && index_s;
    end

    // registered outputs
    logic [15:0] status_reg, speed_reg;
    logic [3:0]  mode_bits_reg;
    logic        halt_reg;
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            status_reg    <= 16'h0000;
            speed_reg     <= 16'h0000;
            mode_bits_reg <= 4'h0;
            halt_reg      <= 1'b0;
        end else if (clk_en) begin
            status_reg    <= status_next;
            speed_reg     <= speed_next;
            mode_bits_reg <= {command_word_reg[9], command_word_reg[6:4]};
            halt_reg      <= halt_next;
        end
    end

    // read mux; serial and id strings have no width yet, so they stay off this port
    // and off process data, which also keeps them read-only by construction
    wire sel_err = reg_addr == drive_ctl_pkg::last_error_code_off;
    wire sel_cmd = reg_addr == drive_ctl_pkg::command_word_off;
    wire sel_sts = reg_addr == drive_ctl_pkg::state_word_off;
    wire sel_spd = reg_addr == drive_ctl_pkg::target_speed_off;
    assign reg_rdata = sel_err ? last_error_reg :
                       sel_cmd ? command_word_reg :
                       sel_sts ? status_reg :
                       sel_spd ? target_speed_reg : 16'h0000;

    assign last_error_code    = last_error_reg;
    assign command_word       = command_word_reg;
    assign state_word         = status_reg;
    assign speed_demand       = speed_reg;
    assign mode_specific_bits = mode_bits_reg;
    assign halt_active        = halt_reg;
    assign power_applied_flag = status_reg[drive_ctl_pkg::sw_power];
    assign run_enable_out     = status_reg[drive_ctl_pkg::sw_running];
endmodule
`default_nettype wire

/* core/drive_ctl_pkg.sv */
// constants for the drive power state control word block
// Summary of operation
// - last error code is a read-only 16-bit value, visible on the register port.
// - error code equals low 16 bits of newest error history entry.
// - serial number and device id strings are read-only, not process-mappable.
// - command bit 0 requests switched-on state.
// - command bit 1 requests voltage enable.
// - command bit 2 low forces quick stop; hold high for normal run.
// - command bit 3 requests operation enabled.
// - command bit 7 clears a fault if clearable, else fault persists.
// - command bit 8 halts motion only in the five listed operating modes.
// - command bits 4 to 6 and 9 are decoded per operating mode.
// - status bit 0 set while ready to switch on.
// - status bit 1 set while switched on.
// - status bit 2 set while operation enabled.
// - status bit 5 reads zero while in quick stop.
// - status bit 6 set while switch-on disabled.
// - status bit 8 shows fieldbus synchronisation.
// - status bit 9 always reads one; the code holds it at zero from reset until the first enabled clock.
// - status bit 15 set once auto setup succeeded and index pulse seen.
// - not-ready is x0xx 0000, switch-on disabled x1xx 0000.
// - ready x01x 0001, switched on x01x 0011, enabled x01x 0111.
// - quick stop x00x 0111, fault reaction x0xx 1111, fault x0xx 1000.
// - target speed signed 16-bit writable, preset 00c8.
// - command word writable 16-bit, preset zero.
// - target speed below minimum is clamped, status bit 11 set.
package drive_ctl_pkg;
    localparam logic [15:0] last_error_code_off = 16'h603f;
    localparam logic [15:0] command_word_off    = 16'h6040;
    localparam logic [15:0] state_word_off      = 16'h6041;
    localparam logic [15:0] target_speed_off    = 16'h6042;
    localparam logic [15:0] command_word_rst    = 16'h0000;
    localparam logic [15:0] target_speed_rst    = 16'h00c8;
    localparam logic [15:0] last_error_rst      = 16'h0000;
    // command word bit positions
    localparam int cw_switch_on  = 0;
    localparam int cw_energize   = 1;
    localparam int cw_fast_halt  = 2;
    localparam int cw_run_enable = 3;
    localparam int cw_clear_fault = 7;
    localparam int cw_halt       = 8;
    // status word bit positions
    localparam int sw_ready      = 0;
    localparam int sw_switched   = 1;
    localparam int sw_running    = 2;
    localparam int sw_fault      = 3;
    localparam int sw_power      = 4;
    localparam int sw_fast_halt  = 5;
    localparam int sw_inhibit    = 6;
    localparam int sw_warn       = 7;
    localparam int sw_sync       = 8;
    localparam int sw_host       = 9;
    localparam int sw_goal       = 10;
    localparam int sw_limit      = 11;
    localparam int sw_loop_ok    = 15;
    // operating mode codes that honour halt
    localparam logic [7:0] mode_profile_pos = 8'h01;
    localparam logic [7:0] mode_velocity    = 8'h02;
    localparam logic [7:0] mode_profile_vel = 8'h03;
    localparam logic [7:0] mode_profile_trq = 8'h04;
    localparam logic [7:0] mode_interp_pos  = 8'h07;
    typedef enum logic [2:0] {
        st_not_ready, st_inhibited, st_ready, st_switched,
        st_running, st_fast_halt, st_fault_react, st_fault
    } power_state_t;
endpackage

/* verif/fieldbus_master.sv */
// fieldbus master model driving the register port of the drive
`timescale 1ns/100ps
`default_nettype none
module fieldbus_master (
    input  wire logic        clk,
    output logic             reg_wr,
    output logic      [15:0] reg_addr,
    output logic      [15:0] reg_wdata,
    input  wire logic [15:0] reg_rdata
);
    initial begin
        reg_wr    = 1'b0;
        reg_addr  = 16'h0000;
        reg_wdata = 16'h0000;
    end
    // one word per call, set at the falling edge and held over one rising edge
    task automatic write(input logic [15:0] a, input logic [15:0] v);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = v;
        reg_wr    = 1'b1;
        @(negedge clk);
        reg_wr    = 1'b0;
        reg_wdata = ~v; // released data must not be mistaken for the last word
    endtask
    // read data is combinational, so it is taken well before the next edge
    task automatic read(input logic [15:0] a, output logic [15:0] v);
        @(negedge clk);
        reg_addr = a;
        #10;
        v = reg_rdata;
    endtask
endmodule
`default_nettype wire

/* verif/drive_ctl_asserts.sv */
// concurrent checks on the drive control word block
`timescale 1ns/100ps
`default_nettype none
module drive_ctl_asserts (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    input wire logic        reg_wr,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [31:0] error_newest,
    input wire logic [7:0]  op_mode,
    input wire logic [15:0] speed_min,
    input wire logic [15:0] last_error_code,
    input wire logic [15:0] command_word,
    input wire logic [15:0] state_word,
    input wire logic [15:0] speed_demand,
    input wire logic [3:0]  mode_specific_bits,
    input wire logic        halt_active
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // writes only count once the internal reset copy has let go
    sequence cmd_write;
        clk_en && reg_wr && reg_addr == 16'h6040 && $past(rst_n, 3);
    endsequence
    sequence speed_low;
        clk_en && reg_wr && reg_addr == 16'h6042 && $past(rst_n, 3)
            && $signed(reg_wdata) < $signed(speed_min);
    endsequence
    cmd_store_a: assert property (cmd_write |=> command_word == $past(reg_wdata))
        else $error("command word not stored");
    speed_clamp_a: assert property (speed_low |-> ##[1:3] (speed_demand == speed_min && state_word[11]))
        else $error("low speed not clamped");
    host_flag_a: assert property ($past(rst_n, 5) && clk_en |-> state_word[9])
        else $error("remote flag low");
    spare_zero_a: assert property (state_word[14] == 1'b0)
        else $error("spare status bit set");
    inhibit_code_a: assert property (state_word[6] |-> state_word[3:0] == 4'h0)
        else $error("inhibit code wrong");
    run_code_a: assert property (state_word[2] && !state_word[3] |-> state_word[1:0] == 2'b11)
        else $error("running code wrong");
    err_track_a: assert property ($past(rst_n, 3) |-> last_error_code == 16'($past(error_newest)))
        else $error("error code not tracking");
    mode_bits_a: assert property ($stable(command_word) && $past(rst_n, 3) |-> mode_specific_bits == {command_word[9], command_word[6:4]})
        else $error("mode bits mismatch");
    halt_valid_a: assert property ((command_word[8] && op_mode == 8'h02) [*3] |-> halt_active)
        else $error("halt missing in valid mode");
    halt_invalid_a: assert property ((command_word[8] && op_mode == 8'h05) [*3] |-> !halt_active)
        else $error("halt in invalid mode");
endmodule
bind drive_ctl drive_ctl_asserts chk (.clk, .rst_n, .clk_en, .reg_wr, .reg_addr, .reg_wdata,
    .error_newest, .op_mode, .speed_min, .last_error_code, .command_word, .state_word,
    .speed_demand, .mode_specific_bits, .halt_active);
`default_nettype wire

/* verif/drive_ctl_test.sv */
// self-checking bench for the drive control word block
`timescale 1ns/100ps
`default_nettype none
module drive_ctl_test;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        reg_wr, fault_in, fault_clearable, fault_react_done, init_done, bus_sync;
    logic        setup_ok, index_seen, goal_reached_flag, warn_in, halt_active;
    logic        power_applied_flag, run_enable_out, clk_en;
    logic [7:0]  op_mode;
    logic [1:0]  mode_status_bits;
    logic [3:0]  mode_specific_bits;
    logic [31:0] error_newest;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, speed_min;
    logic [15:0] last_error_code, command_word, state_word, speed_demand;
    int          n_mismatch = 0;
    int          n_checks = 0;
    // commands and the status they lead to: ready, on, running, fast halt, inhibited
    logic [15:0] cmds [5] = '{16'h0006, 16'h0007, 16'h000f, 16'h000b, 16'h0000};
    logic [15:0] exps [5] = '{16'h0221, 16'h0223, 16'h0227, 16'h0207, 16'h0240};
    logic [15:0] spd [3] = '{16'h0032, 16'hfff0, 16'h01f4};
    logic [15:0] dem [3] = '{16'h0064, 16'h0064, 16'h01f4};
    always #50 clk = ~clk;
    fieldbus_master m (.clk, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata);
    drive_ctl dut (.clk, .rst_n, .clk_en, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
        .error_newest, .fault_in, .fault_clearable, .fault_react_done, .init_done,
        .bus_sync, .setup_ok, .index_seen, .goal_reached_flag, .warn_in, .op_mode,
        .mode_status_bits, .speed_min, .last_error_code, .command_word, .state_word,
        .speed_demand, .mode_specific_bits, .halt_active, .power_applied_flag,
        .run_enable_out);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] v;
        m.read(a, v);
        check(v, exp);
    endtask
    // poll status through the register port; inputs pass synchronisers first
    task automatic status(input logic [15:0] mask, input logic [15:0] exp);
        logic [15:0] v;
        for (int i = 0; i < 12; i++) begin
            m.read(16'h6041, v);
            if ((v & mask) === exp) break;
        end
        check(v & mask, exp);
    endtask
    task automatic summarize;
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        clk_en = 1'b1;
        {fault_in, fault_clearable, fault_react_done, init_done, bus_sync} = 5'h00;
        {setup_ok, index_seen, goal_reached_flag, warn_in} = 4'h0;
        {error_newest, op_mode, mode_status_bits} = 42'h000_0000_0000;
        speed_min = 16'h0064;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        rd(16'h6040, 16'h0000);
        rd(16'h6042, 16'h00c8);
        rd(16'h603f, 16'h0000);
        rd(16'h6041, 16'h0200);
        rd(16'h6043, 16'h0000);
        @(negedge clk);
        init_done = 1'b1;
        status(16'h426f, 16'h0240);
        foreach (cmds[i]) begin
            m.write(16'h6040, cmds[i]);
            status(16'h426f, exps[i]);
            check(16'(run_enable_out), 16'(exps[i][2]));
            check(16'(power_applied_flag), 16'(i < 3));
        end
        // read-only words ignore writes
        m.write(16'h603f, 16'h1234);
        m.write(16'h6041, 16'hffff);
        rd(16'h603f, 16'h0000);
        status(16'h426f, 16'h0240);
        @(negedge clk);
        error_newest = 32'habcd_5a3c;
        repeat (2) @(negedge clk);
        rd(16'h603f, 16'h5a3c);
        @(negedge clk);
        fault_in = 1'b1;
        status(16'h426f, 16'h020f);
        @(negedge clk);
        fault_react_done = 1'b1;
        status(16'h426f, 16'h0208);
        m.write(16'h6040, 16'h0080);
        repeat (4) @(negedge clk);
        status(16'h426f, 16'h0208);
        m.write(16'h6040, 16'h0000);
        @(negedge clk);
        {fault_in, fault_clearable} = 2'b01;
        repeat (3) @(negedge clk);
        m.write(16'h6040, 16'h0080);
        status(16'h426f, 16'h0240);
        @(negedge clk);
        {bus_sync, setup_ok} = 2'b11;
        status(16'h8100, 16'h0100);
        @(negedge clk);
        {index_seen, warn_in, goal_reached_flag, mode_status_bits} = 5'b11110;
        status(16'hfd80, 16'ha580);
        m.write(16'h6040, 16'h0350);
        repeat (2) @(negedge clk);
        check(16'(mode_specific_bits), 16'h000d);
        for (int k = 0; k < 9; k++) begin
            @(negedge clk);
            op_mode = 8'(k);
            repeat (3) @(negedge clk);
            check(16'(halt_active), 16'(k inside {1, 2, 3, 4, 7}));
        end
        foreach (spd[i]) begin
            m.write(16'h6042, spd[i]);
            rd(16'h6042, spd[i]);
            status(16'h0800, (dem[i] != spd[i]) ? 16'h0800 : 16'h0000);
            check(speed_demand, dem[i]);
        end
        // enable low must freeze the command word against a write
        @(negedge clk);
        clk_en = 1'b0;
        m.write(16'h6040, 16'h0001);
        rd(16'h6040, 16'h0350);
        @(negedge clk);
        clk_en = 1'b1;
        m.write(16'h6040, 16'h0001);
        rd(16'h6040, 16'h0001);
        summarize();
    end
    // the sequence needs well under 100 us
    initial begin
        #500_000;
        n_mismatch++;
        summarize();
    end
endmodule
`default_nettype wire
